// File: rtl/n9u_top.sv
// 9-bit serial port with two fixed rates and a classic wishbone register slave
//
// Local design decisions: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`include "n9u_params.svh"
module n9u_top #(
  parameter int DIV_SLOW = `N9U_DIV_SLOW,
  parameter int DIV_FAST = `N9U_DIV_FAST
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic WB_WE_I,
  input wire logic WB_STB_I,
  input wire logic WB_CYC_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic RX_IN,
  output logic TX_OUT,
  output logic IRQ
);

  // ==========================================================
  // declarations
  n9u_pkg::n9u_ctrl_t ctrl_q;
  n9u_pkg::n9u_frame_t rx_buf_q;
  n9u_pkg::n9u_frame_t tx_fr_q;
  n9u_pkg::n9u_tx_st_t tx_st_q;
  n9u_pkg::n9u_rx_st_t rx_st_q;
  logic baud_dbl_q;
  logic [1:0] status_q;
  logic [1:0] status_d;
  logic [1:0] mask_q;
  logic [7:0] addr_q;
  logic [7:0] amask_q;
  logic [6:0] tx_cnt_q;
  logic [2:0] tx_idx_q;
  logic [6:0] rx_cnt_q;
  logic [2:0] rx_idx_q;
  logic [7:0] rx_sh_q;
  logic rx_nine_q;
  logic line_prev_q;
  logic rx_line;

  // decode of one register word
  function automatic logic reg_sel(input logic [7:0] adr, input logic [7:0] off);
    return adr[7:2] == off[7:2];
  endfunction

  // ==========================================================
  // receive pin synchroniser
  n9u_sync u_rx_sync (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .din(RX_IN),
    .dout(rx_line)
  );

  // ==========================================================
  // bit timing; a rate change mid-frame applies to the current bit, which ends at once if already past the new length
  wire [6:0] bit_last = baud_dbl_q ? 7'(DIV_FAST - 1) : 7'(DIV_SLOW - 1);
  wire [6:0] bit_half = {1'b0, bit_last[6:1]};
  wire tx_bit_end = tx_cnt_q >= bit_last;
  wire rx_bit_end = rx_cnt_q >= bit_last;

  // ==========================================================
  // bus decode; ack holds off a second access in the ack cycle
  wire wb_hit = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire wb_wr = wb_hit & WB_WE_I & WB_SEL_I[0];
  wire wr_ctrl = wb_wr & reg_sel(WB_ADR_I, `N9U_OFF_CTRL);
  wire wr_buf = wb_wr & reg_sel(WB_ADR_I, `N9U_OFF_BUF);
  wire wr_power_control_reg = wb_wr & reg_sel(WB_ADR_I, `N9U_OFF_POWER_CONTROL_REG);
  wire wr_stat = wb_wr & reg_sel(WB_ADR_I, `N9U_OFF_STAT);
  wire wr_mask = wb_wr & reg_sel(WB_ADR_I, `N9U_OFF_MASK);
  wire wr_addr = wb_wr & reg_sel(WB_ADR_I, `N9U_OFF_ADDR);
  wire wr_amask = wb_wr & reg_sel(WB_ADR_I, `N9U_OFF_AMASK);

  // ==========================================================
  // read view; flags mirror the status register
  wire tx_busy = tx_st_q != n9u_pkg::TX_IDLE;
  wire [7:0] ctrl_view = {1'b0, tx_busy, ctrl_q.mp_en, ctrl_q.ren, ctrl_q.tx9,
                          rx_buf_q.ninth, status_q};
  wire [7:0] rd_byte =
    reg_sel(WB_ADR_I, `N9U_OFF_CTRL) ? ctrl_view :
    reg_sel(WB_ADR_I, `N9U_OFF_BUF) ? rx_buf_q.data :
    reg_sel(WB_ADR_I, `N9U_OFF_POWER_CONTROL_REG) ? {baud_dbl_q, 7'h00} :
    reg_sel(WB_ADR_I, `N9U_OFF_STAT) ? {6'h00, status_q} :
    reg_sel(WB_ADR_I, `N9U_OFF_MASK) ? {6'h00, mask_q} :
    reg_sel(WB_ADR_I, `N9U_OFF_ADDR) ? addr_q :
    reg_sel(WB_ADR_I, `N9U_OFF_AMASK) ? amask_q : 8'h00;

  // ==========================================================
  // bus answer: one wait state, unmapped reads give zero
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= wb_hit;
      WB_DAT_O <= wb_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // ==========================================================
  // software controls
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      ctrl_q <= '0;
      baud_dbl_q <= 1'b0;
      mask_q <= `N9U_RST_MASK;
      addr_q <= `N9U_RST_ADDR;
      amask_q <= `N9U_RST_AMASK;
    end else begin
      if (wr_ctrl) begin
        ctrl_q.mp_en <= WB_DAT_I[`N9U_CTRL_MPEN];
        ctrl_q.ren <= WB_DAT_I[`N9U_CTRL_REN];
        ctrl_q.tx9 <= WB_DAT_I[`N9U_CTRL_TX9];
      end
      if (wr_power_control_reg) begin
        baud_dbl_q <= WB_DAT_I[`N9U_POWER_CONTROL_REG_DBL];
      end
      if (wr_mask) begin
        mask_q <= WB_DAT_I[1:0];
      end
      if (wr_addr) begin
        addr_q <= WB_DAT_I[7:0];
      end
      if (wr_amask) begin
        amask_q <= WB_DAT_I[7:0];
      end
    end
  end

  // ==========================================================
  // transmitter; a buffer write while busy is dropped
  wire tx_start = wr_buf & ~tx_busy;
  wire tx_done_set = (tx_st_q == n9u_pkg::TX_NINTH) & tx_bit_end;

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      tx_st_q <= n9u_pkg::TX_IDLE;
      tx_cnt_q <= 7'h00;
      tx_idx_q <= 3'h0;
      tx_fr_q <= '0;
      TX_OUT <= 1'b1;
    end else begin
      tx_cnt_q <= (tx_bit_end | ~tx_busy) ? 7'h00 : tx_cnt_q + 7'h01;
      unique case (tx_st_q)
        n9u_pkg::TX_IDLE: begin
          if (tx_start) begin
            tx_st_q <= n9u_pkg::TX_START;
            tx_fr_q <= {ctrl_q.tx9, WB_DAT_I[7:0]};
            TX_OUT <= 1'b0;
          end
        end
        n9u_pkg::TX_START: begin
          if (tx_bit_end) begin
            tx_st_q <= n9u_pkg::TX_DATA;
            tx_idx_q <= 3'h0;
            TX_OUT <= tx_fr_q.data[0];
          end
        end
        n9u_pkg::TX_DATA: begin
          if (tx_bit_end) begin
            tx_fr_q.data <= {1'b0, tx_fr_q.data[7:1]};
            tx_idx_q <= tx_idx_q + 3'h1;
            if (tx_idx_q == 3'h7) begin
              tx_st_q <= n9u_pkg::TX_NINTH;
              TX_OUT <= tx_fr_q.ninth;
            end else begin
              TX_OUT <= tx_fr_q.data[1];
            end
          end
        end
        n9u_pkg::TX_NINTH: begin
          if (tx_bit_end) begin
            tx_st_q <= n9u_pkg::TX_STOP;
            TX_OUT <= 1'b1;
          end
        end
        n9u_pkg::TX_STOP: begin
          if (tx_bit_end) begin
            tx_st_q <= n9u_pkg::TX_IDLE;
          end
        end
        // spare codes of the state word fall back to idle rather than lock up
        default: begin
          tx_st_q <= n9u_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // receiver; a start that is high again at mid-bit is noise
  wire line_fall = line_prev_q & ~rx_line;
  wire rx_end = (rx_st_q == n9u_pkg::RX_STOP) & rx_bit_end;
  wire addr_hit = ((rx_sh_q ^ addr_q) & amask_q) == 8'h00;
  wire rx_accept = rx_end & ~status_q[`N9U_ST_RX]
                 & (~ctrl_q.mp_en | (rx_nine_q & addr_hit));

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      rx_st_q <= n9u_pkg::RX_IDLE;
      rx_cnt_q <= 7'h00;
      rx_idx_q <= 3'h0;
      rx_sh_q <= 8'h00;
      rx_nine_q <= 1'b0;
      line_prev_q <= 1'b1;
    end else begin
      line_prev_q <= rx_line;
      rx_cnt_q <= rx_cnt_q + 7'h01;
      unique case (rx_st_q)
        n9u_pkg::RX_IDLE: begin
          rx_cnt_q <= 7'h00;
          if (ctrl_q.ren & line_fall) begin
            rx_st_q <= n9u_pkg::RX_START;
          end
        end
        n9u_pkg::RX_START: begin
          if (rx_cnt_q >= bit_half) begin
            rx_cnt_q <= 7'h00;
            rx_idx_q <= 3'h0;
            rx_st_q <= rx_line ? n9u_pkg::RX_IDLE : n9u_pkg::RX_DATA;
          end
        end
        n9u_pkg::RX_DATA: begin
          if (rx_bit_end) begin
            rx_cnt_q <= 7'h00;
            rx_sh_q <= {rx_line, rx_sh_q[7:1]};
            rx_idx_q <= rx_idx_q + 3'h1;
            if (rx_idx_q == 3'h7) begin
              rx_st_q <= n9u_pkg::RX_NINTH;
            end
          end
        end
        n9u_pkg::RX_NINTH: begin
          if (rx_bit_end) begin
            rx_cnt_q <= 7'h00;
            rx_nine_q <= rx_line;
            rx_st_q <= n9u_pkg::RX_STOP;
          end
        end
        n9u_pkg::RX_STOP: begin
          if (rx_bit_end) begin
            rx_st_q <= n9u_pkg::RX_IDLE;
          end
        end
        // spare codes of the state word fall back to idle rather than lock up
        default: begin
          rx_st_q <= n9u_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // receive buffer; loaded only on an accepted frame
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      rx_buf_q <= '0;
    end else if (rx_accept) begin
      rx_buf_q <= {rx_nine_q, rx_sh_q};
    end
  end

  // ==========================================================
  // sticky flags; write one clears, a same-cycle set wins
  assign status_d = (status_q & ~(wr_stat ? WB_DAT_I[1:0] : 2'h0))
                  | {tx_done_set, rx_accept};

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      status_q <= 2'h0;
      IRQ <= 1'b0;
    end else begin
      status_q <= status_d;
      IRQ <= |(status_q & mask_q);
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  // transmit side: frame shape, ninth bit source and done timing
  chk_tx_start_low: assert property (tx_start |=> !TX_OUT && tx_st_q == n9u_pkg::TX_START)
    else $error("frame did not start after buffer write");
  chk_tx_ninth_latch: assert property (tx_start |=> tx_fr_q.ninth == $past(ctrl_q.tx9))
    else $error("ninth bit not latched from control at write");
  chk_frame_order: assert property (
    tx_st_q == n9u_pkg::TX_START && tx_bit_end |=> tx_st_q == n9u_pkg::TX_DATA && tx_idx_q == 3'h0)
    else $error("start bit not followed by data bits");
  chk_ninth_tx: assert property (tx_st_q == n9u_pkg::TX_NINTH |-> TX_OUT == tx_fr_q.ninth)
    else $error("ninth bit differs from latched control value");
  chk_tx_done_time: assert property (
    tx_done_set |=> status_q[`N9U_ST_TX] && TX_OUT && tx_st_q == n9u_pkg::TX_STOP)
    else $error("tx done flag not set at stop start");
  chk_stop_high: assert property (tx_st_q == n9u_pkg::TX_STOP |-> TX_OUT)
    else $error("stop bit not high");
  chk_idle_high: assert property (tx_st_q == n9u_pkg::TX_IDLE |-> TX_OUT)
    else $error("line not idle high between frames");
  chk_bit_period: assert property (
    tx_bit_end && tx_busy && $stable(baud_dbl_q) |-> tx_cnt_q == bit_last)
    else $error("bit period length wrong");

  // receive side: start search, ninth capture, accept and reject
  chk_rx_disabled: assert property (
    rx_st_q == n9u_pkg::RX_IDLE && !ctrl_q.ren |=> rx_st_q == n9u_pkg::RX_IDLE)
    else $error("receiver started while disabled");
  chk_start_detect: assert property (
    rx_st_q == n9u_pkg::RX_IDLE && ctrl_q.ren && line_fall |=> rx_st_q == n9u_pkg::RX_START)
    else $error("falling edge missed");
  chk_rx_ninth_take: assert property (
    rx_st_q == n9u_pkg::RX_NINTH && rx_bit_end |=> rx_nine_q == $past(rx_line))
    else $error("ninth bit not captured");
  chk_rx_accept: assert property (
    rx_accept |=> status_q[`N9U_ST_RX] && rx_buf_q == {$past(rx_nine_q), $past(rx_sh_q)})
    else $error("accepted frame not stored");
  chk_rx_reject: assert property (rx_end && !rx_accept |=> $stable(rx_buf_q))
    else $error("rejected frame changed the buffer");
  chk_rx_buf_hold: assert property (!rx_accept |=> $stable(rx_buf_q))
    else $error("buffer moved without an accepted frame");
  chk_rx_flag_keep: assert property (
    rx_end && !rx_accept && !wr_stat |=> $stable(status_q[`N9U_ST_RX]))
    else $error("rejected frame changed the done flag");
  chk_rx_filter: assert property (
    rx_accept |-> !status_q[`N9U_ST_RX]
      && (!ctrl_q.mp_en || (rx_nine_q && (rx_sh_q & amask_q) == (addr_q & amask_q))))
    else $error("frame accepted against filter");

  // interrupt line follows the enabled flags one cycle late
  chk_irq_level: assert property (|(status_q & mask_q) |=> IRQ)
    else $error("interrupt not raised for enabled flag");
  chk_irq_quiet: assert property (!(|(status_q & mask_q)) |=> !IRQ)
    else $error("interrupt raised with no enabled flag");

  // bus slave: one wait state, single-cycle answer, quiet data outside it
  chk_wb_ack_drop: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  chk_wb_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("bus access not answered in one cycle");
  chk_wb_data_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0000_0000)
    else $error("read data not zero outside ack");

endmodule

// File: pkg/n9u_params.svh
// register map, field positions, reset values and rate constants of the 9-bit serial port
//
// Overview of operation
// - frame is start, eight data bits LSB first, ninth bit, stop bit.
// - transmitted ninth bit comes from the tx_ninth_bit control field.
// - received ninth bit goes to rx_ninth_bit; received stop value is ignored.
// - writing the serial buffer starts a frame carrying that byte; a write while a frame is in progress is dropped.
// - tx_done_flag sets when the ninth bit ends and stop time begins.
// - receiver accepts frames any time once receive_enable_bit is one.
// - accept only if rx_done_flag clear and filter off or ninth one plus address match.
// - accepted frame loads buffer, rx_ninth_bit, and sets rx_done_flag.
// - rejected frame leaves buffer, rx_ninth_bit and rx_done_flag unchanged.
// - interrupt requested, when enabled, whenever either done flag sets.
// - bit rate is core clock over 64, or over 32 with baud_doubler.
`ifndef N9U_PARAMS_SVH
`define N9U_PARAMS_SVH

// ==========================================================
// register byte offsets
`define N9U_OFF_CTRL 8'h00
`define N9U_OFF_BUF 8'h04
`define N9U_OFF_POWER_CONTROL_REG 8'h08
`define N9U_OFF_STAT 8'h0C
`define N9U_OFF_MASK 8'h10
`define N9U_OFF_ADDR 8'h14
`define N9U_OFF_AMASK 8'h18

// ==========================================================
// field positions
`define N9U_CTRL_RXDONE 0
`define N9U_CTRL_TXDONE 1
`define N9U_CTRL_RX9 2
`define N9U_CTRL_TX9 3
`define N9U_CTRL_REN 4
`define N9U_CTRL_MPEN 5
`define N9U_CTRL_BUSY 6
`define N9U_POWER_CONTROL_REG_DBL 7
`define N9U_ST_RX 0
`define N9U_ST_TX 1

// ==========================================================
// reset values
`define N9U_RST_ADDR 8'h00
`define N9U_RST_AMASK 8'hFF
`define N9U_RST_MASK 2'h0

// ==========================================================
// core clock divide factors per bit
`define N9U_DIV_SLOW 64
`define N9U_DIV_FAST 32

`endif

// File: pkg/n9u_pkg.sv
// types shared by the 9-bit serial port design
package n9u_pkg;

  // one frame payload: eight data bits plus the ninth bit
  typedef struct packed {
    logic ninth;
    logic [7:0] data;
  } n9u_frame_t;

  // software controls held by the control register
  typedef struct packed {
    logic mp_en;
    logic ren;
    logic tx9;
  } n9u_ctrl_t;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_NINTH, TX_STOP} n9u_tx_st_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP} n9u_rx_st_t;

endpackage

// File: rtl/n9u_sync.sv
// three-stage synchroniser for the receive pin, output moves when stages two and three agree
`timescale 1ns/1ps
module n9u_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // ==========================================================
  // chain; idle level is high so reset to one
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      dout <= 1'b1;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end

endmodule

// File: tb/n9u_peer.sv
// far serial node: sends frames into the port and decodes the frames it sends out
`timescale 1ns/1ps
module n9u_peer (
  input wire logic clk,
  input wire logic [7:0] bit_clks,
  input wire logic line_in,
  output logic line_out
);
  n9u_pkg::n9u_frame_t got_q;
  logic got_stop_q;
  int rx_count = 0;

  // ==========================================================
  // sender
  // the line idles high between frames, as a real node leaves it
  initial line_out = 1'b1;

  // start, eight data bits lsb first, ninth bit, then a chosen stop level
  task automatic send(input n9u_pkg::n9u_frame_t f, input logic stop_val);
    logic [10:0] bits;
    bits = {stop_val, f.ninth, f.data, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line_out <= bits[i];
      repeat (bit_clks) @(posedge clk);
    end
    line_out <= 1'b1;
  endtask

  // ==========================================================
  // receiver
  // sample on falling clock edges so the registered line has settled
  always begin
    @(negedge line_in);
    repeat (bit_clks / 2) @(negedge clk);
    for (int i = 0; i < 9; i++) begin
      repeat (bit_clks) @(negedge clk);
      got_q[i] = line_in;
    end
    repeat (bit_clks) @(negedge clk);
    got_stop_q = line_in;
    rx_count++;
  end
endmodule

// File: tb/tb_n9u_top.sv
// self-checking bench for the 9-bit serial port
`timescale 1ns/1ps
`include "n9u_params.svh"
module tb_n9u_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic we = 1'b0;
  logic stb = 1'b0;
  logic rx, tx, irq, ack;
  logic [7:0] adr = 8'h00;
  logic [7:0] bits_per = 8'h40;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, got;
  logic [8:0] last = 9'h000;
  logic [8:0] fr [6] = '{9'h03C, 9'h15A, 9'h15A, 9'h021, 9'h122, 9'h121};
  logic [5:0] acc = 6'b100101;
  int err_total = 0;
  int checked = 0;
  int cyc_n = 0;

  `define CHECK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end

  n9u_top uut (.REF_CLK(clk), .RST_N(rst_n), .WB_ADR_I(adr), .WB_DAT_I(wdat),
    .WB_SEL_I(4'hF), .WB_WE_I(we), .WB_STB_I(stb), .WB_CYC_I(stb), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .RX_IN(rx), .TX_OUT(tx), .IRQ(irq));
  n9u_peer u_peer (.clk(clk), .bit_clks(bits_per), .line_in(tx), .line_out(rx));

  initial forever #4 clk = ~clk;

  // ==========================================================
  // bus tasks
  // one classic cycle, then one idle cycle so back-to-back calls stay legal
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
    adr <= a;
    we <= w;
    wdat <= {24'h0, d};
    stb <= 1'b1;
    // wait as long as the slave needs; only the hang guard ends a lost answer
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    got = rdat;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    wb(a, 1'b0, 8'h00);
    `CHECK(nm, {24'h0, e}, got)
  endtask

  // start a frame; n counts cycles from the taking edge to the registered interrupt
  task automatic tx_frame(input logic [7:0] d, input int p);
    int n;
    wb(`N9U_OFF_BUF, 1'b1, d);
    n = 1;
    do begin
      @(negedge clk);
      n++;
    end while (irq !== 1'b1 && n < 1000);
    `CHECK("tx done time", 1 + 10 * p, n)
    repeat (p + 8) @(posedge clk);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // hang guard, far above the few thousand cycles the frames need
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`N9U_OFF_CTRL, 8'h00, "ctrl reset");
    rd(`N9U_OFF_AMASK, 8'hFF, "amask reset");
    rd(8'h1C, 8'h00, "unmapped");
    // slow rate, ninth bit one
    wb(`N9U_OFF_MASK, 1'b1, 8'h02);
    wb(`N9U_OFF_CTRL, 1'b1, 8'h08);
    tx_frame(8'hA5, `N9U_DIV_SLOW);
    `CHECK("tx frame", 9'h1A5, u_peer.got_q)
    `CHECK("tx stop", 1'b1, u_peer.got_stop_q)
    rd(`N9U_OFF_STAT, 8'h02, "tx done flag");
    wb(`N9U_OFF_STAT, 1'b1, 8'h02);
    `CHECK("irq cleared", 1'b0, irq)
    // doubled rate, ninth bit zero
    wb(`N9U_OFF_POWER_CONTROL_REG, 1'b1, 8'h80);
    wb(`N9U_OFF_CTRL, 1'b1, 8'h00);
    bits_per <= 8'h20;
    tx_frame(8'h3C, `N9U_DIV_FAST);
    `CHECK("tx frame fast", 9'h03C, u_peer.got_q)
    `CHECK("peer frames", 2, u_peer.rx_count)
    wb(`N9U_OFF_STAT, 1'b1, 8'h02);
    wb(`N9U_OFF_POWER_CONTROL_REG, 1'b1, 8'h00);
    bits_per <= 8'h40;
    // a frame while the receiver is off must leave no trace
    u_peer.send(9'h011, 1'b1);
    rd(`N9U_OFF_STAT, 8'h00, "rx while off");
    wb(`N9U_OFF_ADDR, 1'b1, 8'h21);
    wb(`N9U_OFF_CTRL, 1'b1, 8'h10);
    // frame 0 has a low stop bit; frame 1 meets a full buffer; filter on from frame 3
    for (int i = 0; i < 6; i++) begin
      if (i == 3) wb(`N9U_OFF_CTRL, 1'b1, 8'h30);
      u_peer.send(fr[i], i != 0);
      if (acc[i]) last = fr[i];
      rd(`N9U_OFF_STAT, {7'h0, acc[i] | (i == 1)}, "rx status");
      rd(`N9U_OFF_BUF, last[7:0], "rx buffer");
      rd(`N9U_OFF_CTRL, {2'b00, i > 2, 2'b10, last[8], 1'b0, acc[i] | (i == 1)},
        "rx ctrl");
      if (i == 1) begin
        `CHECK("irq masked", 1'b0, irq)
        wb(`N9U_OFF_MASK, 1'b1, 8'h01);
        `CHECK("irq raised", 1'b1, irq)
      end
      if (i != 0) wb(`N9U_OFF_STAT, 1'b1, 8'h01);
    end
    `CHECK("irq after clear", 1'b0, irq)
    tally_and_finish();
  end
endmodule
